// >>> design/psa_cfg.svh
// Widths, lane counts and saturation limits of the packed SIMD datapath.
// Assumes it is included by the package and the design files only.
`ifndef PSA_CFG_SVH
`define PSA_CFG_SVH

`define PSA_QW 64
`define PSA_BW 8
`define PSA_WW 16
`define PSA_DW 32
`define PSA_NB 8
`define PSA_NW 4
`define PSA_ND 2
`define PSA_EXT 2
`define PSA_OPW 5
`define PSA_S8_MAX 8'h7F
`define PSA_S8_MIN 8'h80
`define PSA_U8_MAX 8'hFF
`define PSA_S16_MAX 16'h7FFF
`define PSA_S16_MIN 16'h8000
`define PSA_U16_MAX 16'hFFFF

`endif

// >>> design/psa_pkg.sv
// Types shared by the packed SIMD datapath and its lane adder.
// Assumes psa_cfg.svh is on the include path.
`include "psa_cfg.svh"

package psa_pkg;

  typedef enum logic [`PSA_OPW-1:0] {
    OP_NARROW_WORD_SIGNED_SAT = 5'h00,
    OP_NARROW_DWORD_SIGNED_SAT = 5'h01,
    OP_NARROW_WORD_UNSIGNED_SAT = 5'h02,
    OP_INTERLEAVE_HIGH = 5'h03,
    OP_INTERLEAVE_LOW = 5'h04,
    OP_LANE_ADD_WRAP = 5'h05,
    OP_LANE_SUB_WRAP = 5'h06,
    OP_LANE_ADD_SIGNED_SAT = 5'h07,
    OP_LANE_ADD_UNSIGNED_SAT = 5'h08,
    OP_LANE_SUB_SIGNED_SAT = 5'h09,
    OP_LANE_SUB_UNSIGNED_SAT = 5'h0A,
    OP_LANE_MUL_UPPER_HALF = 5'h0B,
    OP_LANE_MUL_LOWER_HALF = 5'h0C,
    OP_LANE_MUL_PAIR_SUM = 5'h0D,
    OP_LANE_COMPARE_EQUAL = 5'h0E,
    OP_LANE_COMPARE_GREATER = 5'h0F,
    OP_QUAD_BITWISE_AND = 5'h10,
    OP_QUAD_BITWISE_AND_INVERTED = 5'h11,
    OP_QUAD_BITWISE_OR = 5'h12,
    OP_QUAD_BITWISE_XOR = 5'h13,
    OP_LANE_SHIFT_LEFT_LOGICAL = 5'h14,
    OP_LANE_SHIFT_RIGHT_LOGICAL = 5'h15,
    OP_LANE_SHIFT_RIGHT_ARITH = 5'h16,
    OP_CLEAR_PACKED_STATE = 5'h17
  } psa_op_t;

  typedef enum logic [1:0] {
    PSA_SZ_BYTE = 2'h0,
    PSA_SZ_WORD = 2'h1,
    PSA_SZ_DWORD = 2'h2,
    PSA_SZ_QUAD = 2'h3
  } psa_size_t;

  typedef struct packed {
    logic valid;
    psa_op_t op;
    psa_size_t size;
    logic [`PSA_QW-1:0] a;
    logic [`PSA_QW-1:0] b;
  } psa_req_t;

  typedef struct packed {
    logic valid;
    logic [`PSA_QW-1:0] data;
  } psa_resp_t;

  typedef enum logic [1:0] {
    PSA_ST_EMPTY = 2'b00,
    PSA_ST_ACTIVE = 2'b01
  } psa_state_t;

endpackage : psa_pkg

// >>> design/psa_lane_addsub.sv
// Lane adder and subtractor with wraparound or saturation.
// Assumes the caller selects at most one saturation kind at a time.
`timescale 1ns/10ps
`include "psa_cfg.svh"

module psa_lane_addsub (
  input wire logic [`PSA_QW-1:0] i_a,
  input wire logic [`PSA_QW-1:0] i_b,
  input wire psa_pkg::psa_size_t i_size,
  input wire logic i_sub,
  input wire logic i_sat_s,
  input wire logic i_sat_u,
  output logic [`PSA_QW-1:0] o_sum
);
  import psa_pkg::*;

  always_comb begin
    logic [`PSA_BW+1:0] xa8, xb8, s8;
    logic [`PSA_WW+1:0] xa16, xb16, s16;
    logic [`PSA_QW-1:0] rb, rw, rd;
    xa8 = '0; xb8 = '0; s8 = '0;
    xa16 = '0; xb16 = '0; s16 = '0;
    rb = '0; rw = '0; rd = '0;
    // Two guard bits per byte and word lane catch both signed overflow and unsigned carry or borrow.
    for (int i = 0; i < `PSA_NB; i++) begin
      xa8 = {{`PSA_EXT{i_sat_s & i_a[i*`PSA_BW+`PSA_BW-1]}}, i_a[i*`PSA_BW +: `PSA_BW]};
      xb8 = {{`PSA_EXT{i_sat_s & i_b[i*`PSA_BW+`PSA_BW-1]}}, i_b[i*`PSA_BW +: `PSA_BW]};
      s8 = i_sub ? xa8 - xb8 : xa8 + xb8;
      rb[i*`PSA_BW +: `PSA_BW] = s8[`PSA_BW-1:0];
      if (i_sat_s && (s8[`PSA_BW] != s8[`PSA_BW-1])) begin
        rb[i*`PSA_BW +: `PSA_BW] = s8[`PSA_BW+1] ? `PSA_S8_MIN : `PSA_S8_MAX;
      end
      if (i_sat_u && s8[`PSA_BW+1]) begin
        rb[i*`PSA_BW +: `PSA_BW] = '0;
      end else if (i_sat_u && s8[`PSA_BW]) begin
        rb[i*`PSA_BW +: `PSA_BW] = `PSA_U8_MAX;
      end
    end
    for (int i = 0; i < `PSA_NW; i++) begin
      xa16 = {{`PSA_EXT{i_sat_s & i_a[i*`PSA_WW+`PSA_WW-1]}}, i_a[i*`PSA_WW +: `PSA_WW]};
      xb16 = {{`PSA_EXT{i_sat_s & i_b[i*`PSA_WW+`PSA_WW-1]}}, i_b[i*`PSA_WW +: `PSA_WW]};
      s16 = i_sub ? xa16 - xb16 : xa16 + xb16;
      rw[i*`PSA_WW +: `PSA_WW] = s16[`PSA_WW-1:0];
      if (i_sat_s && (s16[`PSA_WW] != s16[`PSA_WW-1])) begin
        rw[i*`PSA_WW +: `PSA_WW] = s16[`PSA_WW+1] ? `PSA_S16_MIN : `PSA_S16_MAX;
      end
      if (i_sat_u && s16[`PSA_WW+1]) begin
        rw[i*`PSA_WW +: `PSA_WW] = '0;
      end else if (i_sat_u && s16[`PSA_WW]) begin
        rw[i*`PSA_WW +: `PSA_WW] = `PSA_U16_MAX;
      end
    end
    for (int i = 0; i < `PSA_ND; i++) begin
      rd[i*`PSA_DW +: `PSA_DW] = i_sub ? i_a[i*`PSA_DW +: `PSA_DW] - i_b[i*`PSA_DW +: `PSA_DW]
                                       : i_a[i*`PSA_DW +: `PSA_DW] + i_b[i*`PSA_DW +: `PSA_DW];
    end
    case (i_size)
      PSA_SZ_BYTE: o_sum = rb;
      PSA_SZ_WORD: o_sum = rw;
      default: o_sum = rd;
    endcase
  end

endmodule : psa_lane_addsub

// >>> design/psa_alu.sv
// Packed integer SIMD datapath: one request per cycle, result one cycle later.
// Assumes issue logic drives i_req synchronously to i_ref_clk and reads o_resp.
`timescale 1ns/10ps
`include "psa_cfg.svh"

// Contract
// - Signed words narrow to clamped signed bytes
// - Signed dwords narrow to clamped signed words
// - Signed words narrow to clamped unsigned bytes
// - Interleave upper-half elements of both sources
// - Interleave lower-half elements of both sources
// - Lane add wraps, no carry between lanes
// - Lane subtract wraps, no borrow between lanes
// - Signed saturating add clamps byte and word lanes to lane range; dword lanes wrap
// - Unsigned saturating add clamps byte and word lanes at lane maximum; dword lanes wrap
// - Signed saturating subtract clamps byte and word lanes to lane range; dword lanes wrap
// - Unsigned saturating subtract clamps byte and word lanes at zero; dword lanes wrap
// - Signed word multiply keeps upper product half
// - Signed word multiply keeps lower product half
// - Word multiply, adjacent products summed to dwords
// - Per-lane equality compare into destination
// - Per-lane signed greater-than compare
// - Quadword AND, AND-inverted, OR, XOR
// - Logical shifts fill vacated bits with zero
// - Arithmetic right shift replicates lane sign
// - Shifts act on 64-bit operands in lanes
// - Clear command marks packed state empty
module psa_alu (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire psa_pkg::psa_req_t i_req,
  output psa_pkg::psa_resp_t o_resp,
  output logic o_state_empty
);
  import psa_pkg::*;

  // ---------------------------------------------------------------
  // Lane helpers
  // ---------------------------------------------------------------
  function automatic logic [`PSA_BW-1:0] sat_ws(input logic [`PSA_WW-1:0] w);
    if ($signed(w) > $signed({{`PSA_BW{1'b0}}, `PSA_S8_MAX})) begin
      return `PSA_S8_MAX;
    end else if ($signed(w) < $signed({{`PSA_BW{1'b1}}, `PSA_S8_MIN})) begin
      return `PSA_S8_MIN;
    end
    return w[`PSA_BW-1:0];
  endfunction : sat_ws

  function automatic logic [`PSA_WW-1:0] sat_ds(input logic [`PSA_DW-1:0] d);
    if ($signed(d) > $signed({{`PSA_WW{1'b0}}, `PSA_S16_MAX})) begin
      return `PSA_S16_MAX;
    end else if ($signed(d) < $signed({{`PSA_WW{1'b1}}, `PSA_S16_MIN})) begin
      return `PSA_S16_MIN;
    end
    return d[`PSA_WW-1:0];
  endfunction : sat_ds

  function automatic logic [`PSA_BW-1:0] sat_wu(input logic [`PSA_WW-1:0] w);
    if (w[`PSA_WW-1]) begin
      return '0;
    end else if (w > {{`PSA_BW{1'b0}}, `PSA_U8_MAX}) begin
      return `PSA_U8_MAX;
    end
    return w[`PSA_BW-1:0];
  endfunction : sat_wu

  function automatic logic [`PSA_QW-1:0] interleave(input logic [`PSA_QW-1:0] a,
                                                    input logic [`PSA_QW-1:0] b,
                                                    input psa_size_t sz,
                                                    input logic hi);
    logic [`PSA_QW-1:0] r;
    int base;
    r = '0;
    base = 0;
    case (sz)
      PSA_SZ_BYTE: begin
        base = hi ? `PSA_NW : 0;
        for (int k = 0; k < `PSA_NW; k++) begin
          r[2*k*`PSA_BW +: `PSA_BW] = a[(base+k)*`PSA_BW +: `PSA_BW];
          r[(2*k+1)*`PSA_BW +: `PSA_BW] = b[(base+k)*`PSA_BW +: `PSA_BW];
        end
      end
      PSA_SZ_WORD: begin
        base = hi ? `PSA_ND : 0;
        for (int k = 0; k < `PSA_ND; k++) begin
          r[2*k*`PSA_WW +: `PSA_WW] = a[(base+k)*`PSA_WW +: `PSA_WW];
          r[(2*k+1)*`PSA_WW +: `PSA_WW] = b[(base+k)*`PSA_WW +: `PSA_WW];
        end
      end
      default: begin
        r = hi ? {b[`PSA_QW-1:`PSA_DW], a[`PSA_QW-1:`PSA_DW]}
               : {b[`PSA_DW-1:0], a[`PSA_DW-1:0]};
      end
    endcase
    return r;
  endfunction : interleave

  function automatic logic [`PSA_QW-1:0] compare(input logic [`PSA_QW-1:0] a,
                                                 input logic [`PSA_QW-1:0] b,
                                                 input psa_size_t sz,
                                                 input logic gt);
    logic [`PSA_QW-1:0] r;
    logic hit;
    r = '0;
    hit = 1'b0;
    case (sz)
      PSA_SZ_BYTE: begin
        for (int i = 0; i < `PSA_NB; i++) begin
          hit = gt ? ($signed(a[i*`PSA_BW +: `PSA_BW]) > $signed(b[i*`PSA_BW +: `PSA_BW]))
                   : (a[i*`PSA_BW +: `PSA_BW] == b[i*`PSA_BW +: `PSA_BW]);
          r[i*`PSA_BW +: `PSA_BW] = {`PSA_BW{hit}};
        end
      end
      PSA_SZ_WORD: begin
        for (int i = 0; i < `PSA_NW; i++) begin
          hit = gt ? ($signed(a[i*`PSA_WW +: `PSA_WW]) > $signed(b[i*`PSA_WW +: `PSA_WW]))
                   : (a[i*`PSA_WW +: `PSA_WW] == b[i*`PSA_WW +: `PSA_WW]);
          r[i*`PSA_WW +: `PSA_WW] = {`PSA_WW{hit}};
        end
      end
      default: begin
        for (int i = 0; i < `PSA_ND; i++) begin
          hit = gt ? ($signed(a[i*`PSA_DW +: `PSA_DW]) > $signed(b[i*`PSA_DW +: `PSA_DW]))
                   : (a[i*`PSA_DW +: `PSA_DW] == b[i*`PSA_DW +: `PSA_DW]);
          r[i*`PSA_DW +: `PSA_DW] = {`PSA_DW{hit}};
        end
      end
    endcase
    return r;
  endfunction : compare

  // A lane of width w shifted by w or more holds only its fill bit: zero, or its sign for arithmetic right shifts.
  function automatic logic [`PSA_WW-1:0] shift_w(input logic [`PSA_WW-1:0] x,
                                                 input logic [`PSA_QW-1:0] c,
                                                 input psa_op_t op);
    logic fill;
    fill = (op == OP_LANE_SHIFT_RIGHT_ARITH) & x[`PSA_WW-1];
    if (c >= `PSA_QW'(`PSA_WW)) begin
      return {`PSA_WW{fill}};
    end
    case (op)
      OP_LANE_SHIFT_LEFT_LOGICAL: return x << c;
      OP_LANE_SHIFT_RIGHT_ARITH: return `PSA_WW'($signed(x) >>> c);
      default: return x >> c;
    endcase
  endfunction : shift_w

  function automatic logic [`PSA_DW-1:0] shift_d(input logic [`PSA_DW-1:0] x,
                                                 input logic [`PSA_QW-1:0] c,
                                                 input psa_op_t op);
    logic fill;
    fill = (op == OP_LANE_SHIFT_RIGHT_ARITH) & x[`PSA_DW-1];
    if (c >= `PSA_QW'(`PSA_DW)) begin
      return {`PSA_DW{fill}};
    end
    case (op)
      OP_LANE_SHIFT_LEFT_LOGICAL: return x << c;
      OP_LANE_SHIFT_RIGHT_ARITH: return `PSA_DW'($signed(x) >>> c);
      default: return x >> c;
    endcase
  endfunction : shift_d

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  logic [`PSA_QW-1:0] addsub;
  logic [`PSA_DW-1:0] prod [`PSA_NW];
  logic [`PSA_QW-1:0] result;
  psa_resp_t resp_reg;
  psa_state_t state_reg;
  psa_state_t state_next;

  psa_lane_addsub u_addsub (
    .i_a(i_req.a),
    .i_b(i_req.b),
    .i_size(i_req.size),
    .i_sub(i_req.op inside {OP_LANE_SUB_WRAP, OP_LANE_SUB_SIGNED_SAT,
                            OP_LANE_SUB_UNSIGNED_SAT}),
    .i_sat_s(i_req.op inside {OP_LANE_ADD_SIGNED_SAT, OP_LANE_SUB_SIGNED_SAT}),
    .i_sat_u(i_req.op inside {OP_LANE_ADD_UNSIGNED_SAT, OP_LANE_SUB_UNSIGNED_SAT}),
    .o_sum(addsub)
  );

  always_comb begin
    for (int i = 0; i < `PSA_NW; i++) begin
      prod[i] = $signed(i_req.a[i*`PSA_WW +: `PSA_WW]) * $signed(i_req.b[i*`PSA_WW +: `PSA_WW]);
    end
  end

  always_comb begin
    result = '0;
    case (i_req.op)
      OP_NARROW_WORD_SIGNED_SAT: begin
        for (int i = 0; i < `PSA_NW; i++) begin
          result[i*`PSA_BW +: `PSA_BW] = sat_ws(i_req.a[i*`PSA_WW +: `PSA_WW]);
          result[(i+`PSA_NW)*`PSA_BW +: `PSA_BW] = sat_ws(i_req.b[i*`PSA_WW +: `PSA_WW]);
        end
      end
      OP_NARROW_DWORD_SIGNED_SAT: begin
        for (int i = 0; i < `PSA_ND; i++) begin
          result[i*`PSA_WW +: `PSA_WW] = sat_ds(i_req.a[i*`PSA_DW +: `PSA_DW]);
          result[(i+`PSA_ND)*`PSA_WW +: `PSA_WW] = sat_ds(i_req.b[i*`PSA_DW +: `PSA_DW]);
        end
      end
      OP_NARROW_WORD_UNSIGNED_SAT: begin
        for (int i = 0; i < `PSA_NW; i++) begin
          result[i*`PSA_BW +: `PSA_BW] = sat_wu(i_req.a[i*`PSA_WW +: `PSA_WW]);
          result[(i+`PSA_NW)*`PSA_BW +: `PSA_BW] = sat_wu(i_req.b[i*`PSA_WW +: `PSA_WW]);
        end
      end
      OP_INTERLEAVE_HIGH: result = interleave(i_req.a, i_req.b, i_req.size, 1'b1);
      OP_INTERLEAVE_LOW: result = interleave(i_req.a, i_req.b, i_req.size, 1'b0);
      OP_LANE_ADD_WRAP, OP_LANE_SUB_WRAP, OP_LANE_ADD_SIGNED_SAT, OP_LANE_ADD_UNSIGNED_SAT,
      OP_LANE_SUB_SIGNED_SAT, OP_LANE_SUB_UNSIGNED_SAT: result = addsub;
      OP_LANE_MUL_UPPER_HALF: begin
        for (int i = 0; i < `PSA_NW; i++) begin
          result[i*`PSA_WW +: `PSA_WW] = prod[i][`PSA_DW-1:`PSA_WW];
        end
      end
      OP_LANE_MUL_LOWER_HALF: begin
        for (int i = 0; i < `PSA_NW; i++) begin
          result[i*`PSA_WW +: `PSA_WW] = prod[i][`PSA_WW-1:0];
        end
      end
      OP_LANE_MUL_PAIR_SUM: begin
        for (int i = 0; i < `PSA_ND; i++) begin
          result[i*`PSA_DW +: `PSA_DW] = prod[2*i] + prod[2*i+1];
        end
      end
      OP_LANE_COMPARE_EQUAL: result = compare(i_req.a, i_req.b, i_req.size, 1'b0);
      OP_LANE_COMPARE_GREATER: result = compare(i_req.a, i_req.b, i_req.size, 1'b1);
      OP_QUAD_BITWISE_AND: result = i_req.a & i_req.b;
      OP_QUAD_BITWISE_AND_INVERTED: result = ~i_req.a & i_req.b;
      OP_QUAD_BITWISE_OR: result = i_req.a | i_req.b;
      OP_QUAD_BITWISE_XOR: result = i_req.a ^ i_req.b;
      OP_LANE_SHIFT_LEFT_LOGICAL, OP_LANE_SHIFT_RIGHT_LOGICAL, OP_LANE_SHIFT_RIGHT_ARITH: begin
        case (i_req.size)
          PSA_SZ_DWORD: begin
            for (int i = 0; i < `PSA_ND; i++) begin
              result[i*`PSA_DW +: `PSA_DW] = shift_d(i_req.a[i*`PSA_DW +: `PSA_DW], i_req.b,
                                                     i_req.op);
            end
          end
          PSA_SZ_QUAD: begin
            if (i_req.b >= `PSA_QW'(`PSA_QW)) begin
              result = {`PSA_QW{(i_req.op == OP_LANE_SHIFT_RIGHT_ARITH) & i_req.a[`PSA_QW-1]}};
            end else if (i_req.op == OP_LANE_SHIFT_LEFT_LOGICAL) begin
              result = i_req.a << i_req.b;
            end else if (i_req.op == OP_LANE_SHIFT_RIGHT_ARITH) begin
              result = $signed(i_req.a) >>> i_req.b;
            end else begin
              result = i_req.a >> i_req.b;
            end
          end
          default: begin
            for (int i = 0; i < `PSA_NW; i++) begin
              result[i*`PSA_WW +: `PSA_WW] = shift_w(i_req.a[i*`PSA_WW +: `PSA_WW], i_req.b,
                                                     i_req.op);
            end
          end
        endcase
      end
      default: result = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // Result register and packed-state tracking
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      resp_reg <= '0;
    end else if (i_clk_en) begin
      resp_reg.valid <= i_req.valid;
      resp_reg.data <= i_req.valid ? result : resp_reg.data;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PSA_ST_EMPTY: begin
        if (i_req.valid && i_req.op != OP_CLEAR_PACKED_STATE) begin
          state_next = PSA_ST_ACTIVE;
        end
      end
      PSA_ST_ACTIVE: begin
        if (i_req.valid && i_req.op == OP_CLEAR_PACKED_STATE) begin
          state_next = PSA_ST_EMPTY;
        end
      end
      default: state_next = PSA_ST_EMPTY;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_reg <= PSA_ST_EMPTY;
    end else if (i_clk_en) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_state_empty <= 1'b1;
    end else if (i_clk_en) begin
      o_state_empty <= (state_next == PSA_ST_EMPTY);
    end
  end

  assign o_resp = resp_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_issue(psa_op_t o);
    i_clk_en && i_req.valid && i_req.op == o;
  endsequence

  sequence s_issue_sz(psa_op_t o, psa_size_t s);
    s_issue(o) ##0 i_req.size == s;
  endsequence

  property p_narrow_ws;
    s_issue(OP_NARROW_WORD_SIGNED_SAT) ##0 (!i_req.a[15] && i_req.a[14:7] != 8'h00)
      |=> o_resp.valid && o_resp.data[7:0] == `PSA_S8_MAX;
  endproperty
  a_narrow_ws: assert property (p_narrow_ws) else $error("word narrow no clamp");

  property p_narrow_ds;
    s_issue(OP_NARROW_DWORD_SIGNED_SAT) ##0 (i_req.b[31] && i_req.b[30:15] != 16'hFFFF)
      |=> o_resp.data[47:32] == `PSA_S16_MIN;
  endproperty
  a_narrow_ds: assert property (p_narrow_ds) else $error("dword narrow no clamp");

  property p_narrow_wu;
    s_issue(OP_NARROW_WORD_UNSIGNED_SAT) ##0 i_req.a[15] |=> o_resp.data[7:0] == 8'h00;
  endproperty
  a_narrow_wu: assert property (p_narrow_wu) else $error("negative word not zero");

  property p_ilv_hi;
    s_issue_sz(OP_INTERLEAVE_HIGH, PSA_SZ_BYTE) |=> o_resp.data[15:8] == $past(i_req.b[39:32]);
  endproperty
  a_ilv_hi: assert property (p_ilv_hi) else $error("high interleave wrong");

  property p_ilv_lo;
    s_issue_sz(OP_INTERLEAVE_LOW, PSA_SZ_WORD) |=> o_resp.data[31:16] == $past(i_req.b[15:0]);
  endproperty
  a_ilv_lo: assert property (p_ilv_lo) else $error("low interleave wrong");

  property p_add_wrap;
    s_issue_sz(OP_LANE_ADD_WRAP, PSA_SZ_BYTE)
      |=> o_resp.data[15:8] == $past(i_req.a[15:8] + i_req.b[15:8]);
  endproperty
  a_add_wrap: assert property (p_add_wrap) else $error("byte add carried");

  property p_add_ssat;
    s_issue_sz(OP_LANE_ADD_SIGNED_SAT, PSA_SZ_WORD) ##0
      (i_req.a[15:0] == `PSA_S16_MAX && !i_req.b[15] && i_req.b[15:0] != 16'h0000)
      |=> o_resp.data[15:0] == `PSA_S16_MAX;
  endproperty
  a_add_ssat: assert property (p_add_ssat) else $error("signed add no clamp");

  property p_sub_usat;
    s_issue_sz(OP_LANE_SUB_UNSIGNED_SAT, PSA_SZ_BYTE) ##0 (i_req.a[7:0] < i_req.b[7:0])
      |=> o_resp.data[7:0] == 8'h00;
  endproperty
  a_sub_usat: assert property (p_sub_usat) else $error("unsigned sub below zero");

  property p_cmp_eq;
    s_issue_sz(OP_LANE_COMPARE_EQUAL, PSA_SZ_BYTE) ##0 (i_req.a[7:0] == i_req.b[7:0])
      |=> o_resp.data[7:0] == 8'hFF;
  endproperty
  a_cmp_eq: assert property (p_cmp_eq) else $error("equal lane not all ones");

  property p_shift_over;
    s_issue_sz(OP_LANE_SHIFT_LEFT_LOGICAL, PSA_SZ_WORD) ##0 (i_req.b >= 64'h0000000000000010)
      |=> o_resp.data == 64'h0000000000000000;
  endproperty
  a_shift_over: assert property (p_shift_over) else $error("oversized shift not zero");

  property p_sra_sign;
    s_issue_sz(OP_LANE_SHIFT_RIGHT_ARITH, PSA_SZ_DWORD) ##0 i_req.a[31]
      |=> o_resp.data[31] == 1'b1;
  endproperty
  a_sra_sign: assert property (p_sra_sign) else $error("arith shift lost sign");

  property p_clear;
    s_issue(OP_CLEAR_PACKED_STATE) |=> o_state_empty && o_resp.data == 64'h0000000000000000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left state active");

endmodule : psa_alu

// >>> tb/psa_rf_model.sv
// Register file side of the datapath: keeps the latest written result and counts writes.
// Assumes one clock shared with the datapath and the same synchronous reset.
`timescale 1ns/10ps

module psa_rf_model (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire psa_pkg::psa_resp_t i_resp,
  output logic [63:0] o_data,
  output logic [15:0] o_writes
);
  import psa_pkg::*;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_data <= 64'h0;
      o_writes <= 16'h0;
    end else if (i_resp.valid) begin
      o_data <= i_resp.data;
      o_writes <= o_writes + 16'h1;
    end
  end
endmodule : psa_rf_model

// >>> tb/tb.sv
// Self-checking bench for the packed SIMD datapath.
// Assumes psa_pkg, psa_alu and psa_rf_model are compiled before it.
`timescale 1ns/10ps

module tb;
  import psa_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_clk_en = 1'b1;
  psa_req_t i_req = '0;
  psa_resp_t o_resp;
  logic o_state_empty;
  logic [63:0] rf_data;
  logic [15:0] rf_writes;
  int miscompares = 0;
  int cmp_count = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  psa_alu dut_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_req(i_req), .o_resp(o_resp), .o_state_empty(o_state_empty));
  psa_rf_model rf_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_resp(o_resp),
    .o_data(rf_data), .o_writes(rf_writes));

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One request, answer looked at one cycle later.
  task automatic run(input psa_op_t op, input psa_size_t sz, input logic [63:0] a,
                     input logic [63:0] b, input logic [63:0] x, input string nm);
    @(negedge i_ref_clk);
    i_req = '{1'b1, op, sz, a, b};
    @(negedge i_ref_clk);
    chk({nm, " valid"}, {63'h0, o_resp.valid}, 64'h1);
    chk(nm, o_resp.data, x);
    i_req.valid = 1'b0;
  endtask : run

  task automatic t_narrow;
    run(OP_NARROW_WORD_SIGNED_SAT, PSA_SZ_WORD, 64'hFFFF0005FF000080, 64'h0,
        64'h00000000FF05807F, "nws");
    run(OP_NARROW_DWORD_SIGNED_SAT, PSA_SZ_DWORD, 64'hFFFE000000008000, 64'h0,
        64'h0000000080007FFF, "nds");
    run(OP_NARROW_WORD_UNSIGNED_SAT, PSA_SZ_WORD, 64'hFFFF0005FF000080, 64'h0100000000000000,
        64'hFF00000000050080, "nwu");
    $display("narrow done");
  endtask : t_narrow

  task automatic t_interleave;
    logic [63:0] a;
    logic [63:0] b;
    a = 64'h8877665544332211;
    b = 64'hFFEEDDCCBBAA9988;
    run(OP_INTERLEAVE_HIGH, PSA_SZ_BYTE, a, b, 64'hFF88EE77DD66CC55, "ihb");
    run(OP_INTERLEAVE_HIGH, PSA_SZ_DWORD, a, b, 64'hFFEEDDCC88776655, "ihd");
    run(OP_INTERLEAVE_LOW, PSA_SZ_BYTE, a, b, 64'hBB44AA3399228811, "ilb");
    run(OP_INTERLEAVE_LOW, PSA_SZ_WORD, a, b, 64'hBBAA443399882211, "ilw");
    $display("interleave done");
  endtask : t_interleave

  task automatic t_arith;
    run(OP_LANE_ADD_WRAP, PSA_SZ_BYTE, 64'hFF, 64'h1, 64'h0, "addb");
    run(OP_LANE_ADD_WRAP, PSA_SZ_WORD, 64'hFFFF, 64'h1, 64'h0, "addw");
    run(OP_LANE_ADD_WRAP, PSA_SZ_DWORD, 64'hFFFFFFFF, 64'h1, 64'h0, "addd");
    run(OP_LANE_SUB_WRAP, PSA_SZ_BYTE, 64'h0, 64'h1, 64'hFF, "subb");
    run(OP_LANE_SUB_WRAP, PSA_SZ_WORD, 64'h0, 64'h1, 64'hFFFF, "subw");
    run(OP_LANE_ADD_SIGNED_SAT, PSA_SZ_BYTE, 64'h807F, 64'hFF01, 64'h807F, "adss");
    run(OP_LANE_ADD_SIGNED_SAT, PSA_SZ_WORD, 64'h7FFF, 64'h1, 64'h7FFF, "adsw");
    run(OP_LANE_ADD_UNSIGNED_SAT, PSA_SZ_BYTE, 64'h807F, 64'hFF01, 64'hFF80, "adus");
    run(OP_LANE_SUB_SIGNED_SAT, PSA_SZ_WORD, 64'h7FFF8000, 64'hFFFF0001, 64'h7FFF8000,
        "sbss");
    run(OP_LANE_SUB_UNSIGNED_SAT, PSA_SZ_WORD, 64'h7FFF8000, 64'hFFFF0001, 64'h7FFF,
        "sbus");
    run(OP_LANE_SUB_UNSIGNED_SAT, PSA_SZ_BYTE, 64'h0301, 64'h0102, 64'h0200, "sbub");
    $display("arith done");
  endtask : t_arith

  task automatic t_mul;
    run(OP_LANE_MUL_UPPER_HALF, PSA_SZ_WORD, 64'h38000, 64'hFFFF8000, 64'hFFFF4000,
        "mulh");
    run(OP_LANE_MUL_LOWER_HALF, PSA_SZ_WORD, 64'h38000, 64'hFFFF8000, 64'hFFFD0000,
        "mull");
    run(OP_LANE_MUL_PAIR_SUM, PSA_SZ_WORD, 64'h38000, 64'hFFFF8000, 64'h3FFFFFFD,
        "madd");
    $display("multiply done");
  endtask : t_mul

  task automatic t_logic;
    run(OP_LANE_COMPARE_EQUAL, PSA_SZ_BYTE, 64'h0102, 64'h0302, 64'hFFFFFFFFFFFF00FF,
        "ceq");
    run(OP_LANE_COMPARE_GREATER, PSA_SZ_BYTE, 64'h0180, 64'h8001, 64'hFF00, "cgt");
    run(OP_QUAD_BITWISE_AND, PSA_SZ_QUAD, 64'hF0F0, 64'hFF00, 64'hF000, "and");
    run(OP_QUAD_BITWISE_AND_INVERTED, PSA_SZ_QUAD, 64'hF0F0, 64'hFF00, 64'h0F00, "andn");
    run(OP_QUAD_BITWISE_OR, PSA_SZ_QUAD, 64'hF0F0, 64'hFF00, 64'hFFF0, "or");
    run(OP_QUAD_BITWISE_XOR, PSA_SZ_QUAD, 64'hF0F0, 64'hFF00, 64'h0FF0, "xor");
    $display("compare and logic done");
  endtask : t_logic

  task automatic t_shift;
    run(OP_LANE_SHIFT_LEFT_LOGICAL, PSA_SZ_WORD, 64'h8001800180018001, 64'h1,
        64'h0002000200020002, "sllw");
    run(OP_LANE_SHIFT_LEFT_LOGICAL, PSA_SZ_QUAD, 64'h1, 64'h4, 64'h10, "sllq");
    run(OP_LANE_SHIFT_RIGHT_LOGICAL, PSA_SZ_DWORD, 64'h8000000080000000, 64'h4,
        64'h0800000008000000, "srld");
    run(OP_LANE_SHIFT_RIGHT_ARITH, PSA_SZ_WORD, 64'h8000800080008000, 64'h4,
        64'hF800F800F800F800, "sraw");
    run(OP_LANE_SHIFT_RIGHT_ARITH, PSA_SZ_DWORD, 64'h8000000000000010, 64'h20,
        64'hFFFFFFFF00000000, "srad");
    run(OP_LANE_SHIFT_RIGHT_LOGICAL, PSA_SZ_QUAD, 64'hFFFF, 64'h40, 64'h0, "srlq");
    run(OP_LANE_SHIFT_LEFT_LOGICAL, PSA_SZ_WORD, 64'hFFFF, 64'h10, 64'h0, "sllo");
    $display("shift done");
  endtask : t_shift

  task automatic t_clear;
    logic [15:0] n;
    run(OP_QUAD_BITWISE_XOR, PSA_SZ_QUAD, 64'h5, 64'h3, 64'h6, "xor2");
    chk("active", {63'h0, o_state_empty}, 64'h0);
    run(OP_CLEAR_PACKED_STATE, PSA_SZ_QUAD, 64'h5, 64'h3, 64'h0, "clr");
    chk("empty", {63'h0, o_state_empty}, 64'h1);
    chk("rf data", rf_data, 64'h6);
    @(negedge i_ref_clk);
    n = rf_writes;
    i_clk_en = 1'b0;
    i_req = '{1'b1, OP_QUAD_BITWISE_OR, PSA_SZ_QUAD, 64'h1, 64'h2};
    @(negedge i_ref_clk);
    chk("frozen data", o_resp.data, 64'h0);
    chk("frozen empty", {63'h0, o_state_empty}, 64'h1);
    chk("writes", {48'h0, rf_writes}, {48'h0, n});
    i_clk_en = 1'b1;
    i_req.valid = 1'b0;
    $display("clear done");
  endtask : t_clear

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk("reset valid", {63'h0, o_resp.valid}, 64'h0);
    chk("reset empty", {63'h0, o_state_empty}, 64'h1);
    i_sys_rst = 1'b0;
    t_narrow();
    t_interleave();
    t_arith();
    t_mul();
    t_logic();
    t_shift();
    t_clear();
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge i_ref_clk);
    miscompares++;
    end_of_test();
  end
endmodule : tb
